// >>> rtl/vic_pkg.sv
// constants, tables and state layout of the vectored interrupt controller
package vic_pkg;

    // apb geometry
    localparam int ADDR_W = 8;                  // byte address width seen by the slave
    localparam int DATA_W = 32;                 // apb data width
    localparam int REG_W  = 8;                  // implemented width of each control register

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL_PIN_PROX_ADC = 8'h00; // irq_ctrl_pin_prox_adc
    localparam logic [ADDR_W-1:0] OFS_CTRL_EEP_LV_TMR   = 8'h04; // irq_ctrl_eeprom_lowvolt_timer
    localparam logic [ADDR_W-1:0] OFS_CTRL_SER_TB       = 8'h08; // irq_ctrl_serial_timebase
    localparam logic [ADDR_W-1:0] OFS_STATUS            = 8'h0c; // read-only service status
    localparam int NREG = 3;                    // number of control registers

    // register reset values
    localparam logic [REG_W-1:0] CTRL_RESET = 8'h00;

    // global enable position in the first control register
    localparam int GIE_BIT = 0;

    // status register fields
    localparam int STAT_SRC_LSB  = 0;           // last serviced source index, 4 bits
    localparam int STAT_INSVC    = 7;           // a service routine is running
    localparam int STAT_STKFULL  = 6;           // stack full seen by the controller
    localparam int STAT_PENDING  = 5;           // an enabled request is pending

    // sources, in priority order: lowest index has lowest vector and wins
    localparam int NSRC  = 10;
    localparam int SRC_W = 4;
    // 0 ext pin, 1 proximity, 2 a/d, 3 timer p, 4 timer a,
    // 5 low voltage, 6 eeprom, 7 time base 0, 8 time base 1, 9 serial
    localparam int SRC_REG      [NSRC] = '{0, 0, 0, 1, 1, 1, 1, 2, 2, 2};
    localparam int SRC_FLAG_BIT [NSRC] = '{4, 5, 6, 4, 5, 6, 7, 4, 5, 6};
    localparam int SRC_EN_BIT   [NSRC] = '{1, 2, 3, 0, 1, 2, 3, 0, 1, 2};

    // program counter width and default vector spacing
    localparam int PC_W = 12;
    localparam logic [PC_W-1:0] VEC_BASE_DEF = 12'h000; // vector of source i is base + step*(i+1)
    localparam logic [PC_W-1:0] VEC_STEP_DEF = 12'h004;

    // whole state of the controller
    typedef struct packed {
        logic [NSRC-1:0]   flag;                // request flags
        logic [NSRC-1:0]   enab;                // individual enables
        logic              gie;                 // global enable
        logic              pready;              // apb ready
        logic              pslverr;             // apb error
        logic [DATA_W-1:0] prdata;              // apb read data
        logic              push;                // push request to the stack
        logic [PC_W-1:0]   push_pc;             // value to push
        logic              load;                // load program counter
        logic [PC_W-1:0]   load_pc;             // vector to load
        logic              pop;                 // pop request on return
        logic              wake;                // wake-up pulse
        logic [SRC_W-1:0]  last_src;            // last serviced source
        logic              in_service;          // between take and return
    } vic_state_s;

endpackage

// >>> rtl/vic_ctrl.sv
// vectored interrupt controller with apb register access
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - event sets its flag regardless of enables
// - flag plus enable redirects to source vector
// - disabled source keeps flag, no jump
// - global enable low blocks every interrupt
// - taking pushes next-instruction address
// - program counter loads source vector in the same cycle as the push
// - every source has its own vector
// - return pops saved address, resumes program
// - taking clears global enable, no nesting
// - flags still latch while globally blocked
// - full stack holds off all acknowledgement
// - simultaneous requests served by fixed priority
// - any flag becoming set wakes device
// - eeprom and low-voltage bits, reset zero
// - timer a flag bit5, enable bit1
// - timer p flag bit4, enable bit0
// - serial flag bit6, enable bit2
// - time base flags bits5,4, enables 1,0
// - serial register bits 7,3 read zero
// - one means request or enabled
// - serviced source flag clears with global enable
// - global enable lives in pin register
module vic_ctrl #(
    parameter logic [vic_pkg::PC_W-1:0] VEC_BASE = vic_pkg::VEC_BASE_DEF, // vector origin
    parameter logic [vic_pkg::PC_W-1:0] VEC_STEP = vic_pkg::VEC_STEP_DEF  // vector spacing
) (
    // clock and reset
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    // apb slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [vic_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [vic_pkg::DATA_W-1:0]  pwdata,
    output logic                             pready,
    output logic [vic_pkg::DATA_W-1:0]       prdata,
    output logic                             pslverr,
    // source events, one-cycle pulses
    input  wire logic [vic_pkg::NSRC-1:0]    src_event,
    // core sequencer
    input  wire logic                        insn_boundary,
    input  wire logic [vic_pkg::PC_W-1:0]    pc_next,
    input  wire logic                        stack_full,
    input  wire logic                        return_from_interrupt_exec,
    output logic                             stack_push,
    output logic [vic_pkg::PC_W-1:0]         stack_push_pc,
    output logic                             pc_load,
    output logic [vic_pkg::PC_W-1:0]         pc_load_vector,
    output logic                             stack_pop,
    // power control
    output logic                             wake_req
);

    // registered state and its next value
    vic_pkg::vic_state_s st_ff;                 // current state
    vic_pkg::vic_state_s nxt_st;                // next state

    // bus phase decode
    logic                       setup_ph;       // apb setup cycle
    logic                       access_ph;      // access edge where transfer completes
    logic                       wr_acc;         // write takes effect now
    logic [vic_pkg::NREG-1:0]   reg_hit;        // write address hits control register n

    // per-source write decode
    logic [vic_pkg::NSRC-1:0]   src_wr;         // write hits the source's register
    logic [vic_pkg::NSRC-1:0]   wr_flag_val;    // written flag value
    logic [vic_pkg::NSRC-1:0]   wr_en_val;      // written enable value

    // arbitration
    logic [vic_pkg::NSRC-1:0]   pend;           // enabled pending requests
    logic                       pend_any;       // at least one pending
    logic [vic_pkg::SRC_W-1:0]  sel;            // winning source
    logic                       take;           // interrupt taken this cycle
    logic [vic_pkg::PC_W-1:0]   sel_vec;        // vector of the winner

    // phase decode of the apb handshake
    assign setup_ph  = psel && !penable;
    assign access_ph = psel && penable && st_ff.pready;
    assign wr_acc    = access_ph && pwrite;
    assign reg_hit[0] = (paddr == vic_pkg::OFS_CTRL_PIN_PROX_ADC);
    assign reg_hit[1] = (paddr == vic_pkg::OFS_CTRL_EEP_LV_TMR);
    assign reg_hit[2] = (paddr == vic_pkg::OFS_CTRL_SER_TB);

    // per-source register bit decode
    for (genvar gi = 0; gi < vic_pkg::NSRC; gi++)
    begin : g_src
        assign src_wr[gi]      = wr_acc && reg_hit[vic_pkg::SRC_REG[gi]];
        assign wr_flag_val[gi] = pwdata[vic_pkg::SRC_FLAG_BIT[gi]];
        assign wr_en_val[gi]   = pwdata[vic_pkg::SRC_EN_BIT[gi]];
    end

    // enabled requests and lowest-index winner
    always_comb
    begin
        pend     = st_ff.flag & st_ff.enab;
        pend_any = |pend;
        sel      = '0;
        // scan downward so the lowest index is left last
        for (int i = vic_pkg::NSRC - 1; i >= 0; i--)
        begin
            if (pend[i])
            begin
                sel = vic_pkg::SRC_W'(i);
            end
        end
        // acknowledge only at an instruction boundary with room on the stack
        take    = st_ff.gie && pend_any && !stack_full && insn_boundary;
        // distinct vector per source
        sel_vec = vic_pkg::PC_W'(int'(VEC_BASE) + int'(VEC_STEP) * (int'(sel) + 1));
    end

    // next-state logic
    always_comb
    begin
        logic [vic_pkg::REG_W-1:0] rd_reg [vic_pkg::NREG]; // read view of control registers
        logic [vic_pkg::REG_W-1:0] rd_val;                 // selected read byte
        logic                      rd_ok;                  // address mapped
        rd_reg[0] = vic_pkg::CTRL_RESET;
        rd_reg[1] = vic_pkg::CTRL_RESET;
        rd_reg[2] = vic_pkg::CTRL_RESET;
        rd_val    = vic_pkg::CTRL_RESET;
        rd_ok     = 1'b0;

        nxt_st         = st_ff;
        // pulses default low
        nxt_st.pready  = 1'b0;
        nxt_st.pslverr = 1'b0;
        nxt_st.push    = 1'b0;
        nxt_st.load    = 1'b0;
        nxt_st.pop     = 1'b0;
        nxt_st.wake    = 1'b0;

        // assemble read view; unlisted bits stay zero
        for (int i = 0; i < vic_pkg::NSRC; i++)
        begin
            rd_reg[vic_pkg::SRC_REG[i]][vic_pkg::SRC_FLAG_BIT[i]] = st_ff.flag[i];
            rd_reg[vic_pkg::SRC_REG[i]][vic_pkg::SRC_EN_BIT[i]]   = st_ff.enab[i];
        end
        // global enable shares the pin register
        rd_reg[0][vic_pkg::GIE_BIT] = st_ff.gie;
        // bits 7 and 3 of the serial/time-base register are never set above

        // read mux, prepared in the setup cycle
        case (paddr)
            // pin, proximity and a/d register
            vic_pkg::OFS_CTRL_PIN_PROX_ADC:
            begin
                rd_val = rd_reg[0];
                rd_ok  = 1'b1;
            end
            // eeprom, low-voltage and timer register
            vic_pkg::OFS_CTRL_EEP_LV_TMR:
            begin
                rd_val = rd_reg[1];
                rd_ok  = 1'b1;
            end
            // serial and time-base register
            vic_pkg::OFS_CTRL_SER_TB:
            begin
                rd_val = rd_reg[2];
                rd_ok  = 1'b1;
            end
            // read-only service status
            vic_pkg::OFS_STATUS:
            begin
                rd_val = vic_pkg::CTRL_RESET;
                rd_val[vic_pkg::STAT_SRC_LSB +: vic_pkg::SRC_W] = st_ff.last_src;
                rd_val[vic_pkg::STAT_PENDING] = pend_any;
                rd_val[vic_pkg::STAT_STKFULL] = stack_full;
                rd_val[vic_pkg::STAT_INSVC]   = st_ff.in_service;
                rd_ok  = 1'b1;
            end
            // unmapped address answers with an error
            default:
            begin
                rd_val = vic_pkg::CTRL_RESET;
                rd_ok  = 1'b0;
            end
        endcase

        // zero-wait answer: ready rises for the access cycle
        if (setup_ph)
        begin
            nxt_st.pready  = 1'b1;
            // error only for unmapped addresses
            nxt_st.pslverr = !rd_ok;
            nxt_st.prdata  = pwrite ? '0 : {{(vic_pkg::DATA_W - vic_pkg::REG_W){1'b0}}, rd_val};
        end

        // software writes: flags take the written value, a one sets like an event
        for (int i = 0; i < vic_pkg::NSRC; i++)
        begin
            if (src_wr[i])
            begin
                nxt_st.flag[i] = wr_flag_val[i];
                // enables follow the written bits
                nxt_st.enab[i] = wr_en_val[i];
            end
        end
        if (wr_acc && reg_hit[0])
        begin
            nxt_st.gie = pwdata[vic_pkg::GIE_BIT];
        end

        // taking an interrupt: push, vector load, auto clears
        if (take)
        begin
            // take beats a same-cycle global enable write
            nxt_st.push       = 1'b1;
            nxt_st.push_pc    = pc_next;
            nxt_st.load       = 1'b1;
            nxt_st.load_pc    = sel_vec;
            nxt_st.flag[sel]  = 1'b0;
            nxt_st.gie        = 1'b0;
            nxt_st.last_src   = sel;
            nxt_st.in_service = 1'b1;
        end

        // return from the service routine pops the saved address
        if (return_from_interrupt_exec)
        begin
            // routine has ended
            nxt_st.pop        = 1'b1;
            nxt_st.in_service = 1'b0;
        end

        // hardware events last so a set beats any clear in the same cycle
        nxt_st.flag = nxt_st.flag | src_event;

        // wake on any flag going from clear to set
        nxt_st.wake = |(nxt_st.flag & ~st_ff.flag);
    end

    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            // all flags, enables and pulses clear
            st_ff <= '0;
        end
        else
        begin
            // register the prepared next state
            st_ff <= nxt_st;
        end
    end

    // outputs straight from the state register
    assign pready         = st_ff.pready;
    assign prdata         = st_ff.prdata;
    assign pslverr        = st_ff.pslverr;
    assign stack_push     = st_ff.push;
    assign stack_push_pc  = st_ff.push_pc;
    assign pc_load        = st_ff.load;
    assign pc_load_vector = st_ff.load_pc;
    assign stack_pop      = st_ff.pop;
    assign wake_req       = st_ff.wake;

    // event always lands in its flag
    a_event_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (src_event != '0) |=> ((st_ff.flag & $past(src_event)) == $past(src_event)))
        else $error("event did not set its flag");

    // disabled pending flags survive untouched
    a_disabled_kept: assert property (@(posedge pclk) disable iff (!presetn)
        (!wr_acc && ((st_ff.flag & ~st_ff.enab) != '0))
        |=> ((st_ff.flag & $past(st_ff.flag & ~st_ff.enab)) == $past(st_ff.flag & ~st_ff.enab)))
        else $error("disabled flag was lost");

    // push only after an enabled, globally allowed request
    a_push_cause: assert property (@(posedge pclk) disable iff (!presetn)
        st_ff.push |-> ($past(pend_any) && $past(st_ff.gie) && $past(insn_boundary)))
        else $error("push without an enabled request");

    // global enable low means no push next cycle
    a_gie_blocks: assert property (@(posedge pclk) disable iff (!presetn)
        !st_ff.gie |=> !st_ff.push)
        else $error("interrupt taken with global enable off");

    // pushed value is the next-instruction address
    a_push_value: assert property (@(posedge pclk) disable iff (!presetn)
        take |=> (st_ff.push && st_ff.push_pc == $past(pc_next)))
        else $error("wrong address pushed");

    // vector load accompanies the push with the winner's vector
    a_vector_load: assert property (@(posedge pclk) disable iff (!presetn)
        take |=> (st_ff.load && st_ff.push &&
                  st_ff.load_pc == vic_pkg::PC_W'(int'(VEC_BASE) + int'(VEC_STEP) * (int'($past(sel)) + 1))))
        else $error("wrong vector loaded");

    // return produces a pop pulse and ends the service
    a_return_from_interrupt_pop: assert property (@(posedge pclk) disable iff (!presetn)
        return_from_interrupt_exec |=> (st_ff.pop && !st_ff.in_service))
        else $error("return did not pop");

    // taking clears the global enable and the winner's flag
    a_take_clears: assert property (@(posedge pclk) disable iff (!presetn)
        (take && !src_event[sel]) |=> (!st_ff.gie && !st_ff.flag[$past(sel)]))
        else $error("take did not clear enable and flag");

    // full stack holds acknowledgement off
    a_stack_full_hold: assert property (@(posedge pclk) disable iff (!presetn)
        stack_full |=> !st_ff.push)
        else $error("interrupt acknowledged with stack full");

    // winner has no lower pending source
    a_lowest_first: assert property (@(posedge pclk) disable iff (!presetn)
        take |-> ((pend & ((vic_pkg::NSRC'(1) << sel) - vic_pkg::NSRC'(1))) == '0))
        else $error("priority order violated");

    // newly set flag raises wake
    a_wake_on_set: assert property (@(posedge pclk) disable iff (!presetn)
        ((src_event & ~st_ff.flag) != '0) |=> st_ff.wake)
        else $error("no wake for a new flag");

    // unimplemented bits read zero
    a_unimpl_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (access_ph && !pwrite && paddr == vic_pkg::OFS_CTRL_SER_TB) |-> (prdata[7] == 1'b0 && prdata[3] == 1'b0))
        else $error("unimplemented bit read as one");

    // a written one lands in its flag
    a_flag_write_set: assert property (@(posedge pclk) disable iff (!presetn)
        (!take && ((src_wr & wr_flag_val) != '0))
        |=> ((st_ff.flag & $past(src_wr & wr_flag_val)) == $past(src_wr & wr_flag_val)))
        else $error("written flag did not set");

    // a written zero clears its flag unless an event arrives
    a_flag_write_clr: assert property (@(posedge pclk) disable iff (!presetn)
        ((src_event == '0) && ((src_wr & ~wr_flag_val) != '0))
        |=> ((st_ff.flag & $past(src_wr & ~wr_flag_val)) == '0))
        else $error("written zero did not clear flag");

    // enables take the written bits
    a_enab_write: assert property (@(posedge pclk) disable iff (!presetn)
        (src_wr != '0)
        |=> ((st_ff.enab & $past(src_wr)) == $past(src_wr & wr_en_val)))
        else $error("enable write lost");

    // global enable follows a write unless a take clears it
    a_gie_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && reg_hit[0] && !take)
        |=> (st_ff.gie == $past(pwdata[vic_pkg::GIE_BIT])))
        else $error("global enable write lost");

    // pop only after a return
    a_pop_cause: assert property (@(posedge pclk) disable iff (!presetn)
        st_ff.pop
        |-> $past(return_from_interrupt_exec))
        else $error("pop without a return");

    // wake only when a flag went from clear to set
    a_wake_cause: assert property (@(posedge pclk) disable iff (!presetn)
        st_ff.wake
        |-> ((st_ff.flag & ~$past(st_ff.flag)) != '0))
        else $error("wake without a new flag");

    // status read shows the stack state
    a_status_full: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_ph && !pwrite && (paddr == vic_pkg::OFS_STATUS))
        |=> (st_ff.prdata[vic_pkg::STAT_STKFULL] == $past(stack_full)))
        else $error("status misreports full stack");

endmodule

`default_nettype wire

// >>> tb/vic_core_model.sv
// core sequencer and return stack model facing the interrupt controller
`timescale 1ns/100ps
`default_nettype none
module vic_core_model #(
    parameter int                       DEPTH = 2,      // stack slots
    parameter logic [vic_pkg::PC_W-1:0] PC0   = 12'h200 // start address
) (
    // clock and reset
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    // bench commands
    input  wire logic                     bnd_in,
    input  wire logic                     return_from_interrupt_cmd,
    // controller side
    input  wire logic                     stack_push,
    input  wire logic [vic_pkg::PC_W-1:0] stack_push_pc,
    input  wire logic                     pc_load,
    input  wire logic [vic_pkg::PC_W-1:0] pc_load_vector,
    input  wire logic                     stack_pop,
    output logic                          insn_boundary,
    output logic [vic_pkg::PC_W-1:0]      pc_next,
    output logic                          stack_full,
    output logic                          return_from_interrupt_exec
);
    logic [vic_pkg::PC_W-1:0] stk_ff [DEPTH]; // saved return addresses
    int                       depth_ff;       // filled slots
    // status toward the controller
    assign insn_boundary = bnd_in;
    assign stack_full    = (depth_ff == DEPTH);
    assign return_from_interrupt_exec     = return_from_interrupt_cmd && (depth_ff != 0);
    // sequencer: step, vector load, push and pop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pc_next  <= PC0;
            depth_ff <= 0;
        end
        else if (stack_push && pc_load && depth_ff < DEPTH)
        begin
            stk_ff[depth_ff] <= stack_push_pc;
            depth_ff         <= depth_ff + 1;
            pc_next          <= pc_load_vector;
        end
        else if (stack_pop && depth_ff != 0)
        begin
            pc_next  <= stk_ff[depth_ff-1];
            depth_ff <= depth_ff - 1;
        end
        else if (bnd_in)
            pc_next <= pc_next + 12'h001; // plain program flow
    end
endmodule
`default_nettype wire

// >>> tb/vic_ctrl_tb_top.sv
// self-checking bench of the interrupt controller
`timescale 1ns/100ps
`default_nettype none
module vectored_interrupt_controller_tb_top;
    localparam logic [11:0] VB = 12'h100;    // vector origin used here
    localparam logic [11:0] VS = 12'h008;    // vector spacing used here
    localparam int          FB [10] = '{4, 5, 6, 4, 5, 6, 7, 4, 5, 6}; // flag bit of source
    localparam int          RG [10] = '{0, 0, 0, 1, 1, 1, 1, 2, 2, 2}; // register of source
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, er, bnd = 1, return_from_interrupt_cmd = 0, stack_full, return_from_interrupt_exec;
    logic [9:0]  src_event = 10'h000;
    logic        insn_boundary, stack_push, pc_load, stack_pop, wake_req;
    logic [11:0] pc_next, stack_push_pc, pc_load_vector, prev_pc, last_vec;
    int          bad_count = 0, samples_checked = 0, takes = 0, pops = 0, wakes = 0, t0, w0;
    logic [7:0]  ex [3];                      // expected register images
    // clock
    always #4 pclk = ~pclk;
    vic_ctrl #(.VEC_BASE(VB), .VEC_STEP(VS)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .src_event(src_event), .insn_boundary(insn_boundary),
        .pc_next(pc_next), .stack_full(stack_full), .return_from_interrupt_exec(return_from_interrupt_exec), .stack_push(stack_push),
        .stack_push_pc(stack_push_pc), .pc_load(pc_load), .pc_load_vector(pc_load_vector),
        .stack_pop(stack_pop), .wake_req(wake_req));
    vic_core_model #(.DEPTH(2)) core_u (.pclk(pclk), .presetn(presetn), .bnd_in(bnd),
        .return_from_interrupt_cmd(return_from_interrupt_cmd), .stack_push(stack_push), .stack_push_pc(stack_push_pc), .pc_load(pc_load),
        .pc_load_vector(pc_load_vector), .stack_pop(stack_pop), .insn_boundary(insn_boundary),
        .pc_next(pc_next), .stack_full(stack_full), .return_from_interrupt_exec(return_from_interrupt_exec));
    // compare and count
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (e !== g)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // expected vector of a source
    function automatic logic [11:0] vec(input int i);
        return VB + VS * 12'(i + 1);
    endfunction
    // byte address of a control register
    function automatic logic [7:0] ofs(input int r);
        return (r == 0) ? vic_pkg::OFS_CTRL_PIN_PROX_ADC :
               (r == 1) ? vic_pkg::OFS_CTRL_EEP_LV_TMR : vic_pkg::OFS_CTRL_SER_TB;
    endfunction
    // one apb transfer, idle cycle before setup
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        chk("apb_ready", 1, pready);
        rd = prdata;
        er = pslverr;
        psel <= 0; penable <= 0;
    endtask
    // wait for one more take, bounded
    task automatic wait_take(input int t);
        int n;
        n = 0;
        while (takes == t && n < 200)
        begin
            @(posedge pclk);
            n++;
        end
        chk("take_count", t + 1, takes);
    endtask
    // return from service through the core model
    task automatic do_return_from_interrupt();
        int p;
        p = pops;
        @(posedge pclk) return_from_interrupt_cmd <= 1;
        @(posedge pclk) return_from_interrupt_cmd <= 0;
        repeat (4) @(posedge pclk);
        chk("pop_count", p + 1, pops);
    endtask
    // set the global enable without disturbing the flags
    task automatic set_gie();
        apb(0, ofs(0), 0);
        apb(1, ofs(0), rd | 32'h1);
    endtask
    // monitor of core-side pulses, random instruction boundaries
    always @(posedge pclk)
    begin
        bnd <= ($urandom % 4) != 0;
        prev_pc <= pc_next;
        if (wake_req === 1'b1) wakes++;
        if (stack_pop === 1'b1) pops++;
        if (stack_push === 1'b1)
        begin
            takes++;
            last_vec = pc_load_vector;
            chk("pc_load", 1, pc_load);
            chk("push_pc", prev_pc, stack_push_pc);
        end
    end
    // closing verdict
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // hang guard
    initial
    begin
        #400000;
        bad_count++;
        summarize();
    end
    // main sequence
    initial
    begin
        void'($urandom(14));
        repeat (10) @(posedge pclk);
        presetn <= 1;
        for (int r = 0; r < 3; r++)
        begin
            apb(0, ofs(r), 0);
            chk("reset_value", 0, rd);
        end
        apb(0, 8'h10, 0);
        chk("unmapped_err", 1, er);
        // random images read back through the mask of the eeprom/timer and serial/time-base registers
        for (int k = 0; k < 4; k++)
        begin
            t0 = $urandom;
            apb(1, ofs(1), t0);
            apb(0, ofs(1), 0);
            chk("reg1_rw", t0 & 32'hff, rd);
            apb(1, ofs(2), t0);
            apb(0, ofs(2), 0);
            chk("reg2_rw", t0 & 32'h77, rd);
        end
        apb(1, ofs(1), 0);
        apb(1, ofs(2), 0);
        ex = '{8'h01, 8'h00, 8'h00};
        apb(1, ofs(0), 1);
        // every event latches its flag and wakes, no enables
        for (int i = 0; i < 10; i++)
        begin
            w0 = wakes;
            @(posedge pclk) src_event <= 10'(1 << i);
            @(posedge pclk) src_event <= 0;
            repeat (3) @(posedge pclk);
            chk("wake_count", w0 + 1, wakes);
            ex[RG[i]] |= 8'(1 << FB[i]);
            apb(0, ofs(RG[i]), 0);
            chk("flag_set", ex[RG[i]], rd);
        end
        chk("no_take_disabled", 0, takes);
        w0 = wakes;
        @(posedge pclk) src_event <= 10'h008;
        @(posedge pclk) src_event <= 0;
        repeat (4) @(posedge pclk);
        chk("preset_no_wake", w0, wakes);
        // everything pending and enabled, global enable low
        apb(1, ofs(0), 8'h7e);
        apb(1, ofs(1), 8'hff);
        apb(1, ofs(2), 8'h77);
        repeat (20) @(posedge pclk);
        chk("no_take_gie_low", 0, takes);
        // serviced one by one, lowest vector first
        for (int i = 0; i < 10; i++)
        begin
            t0 = takes;
            set_gie();
            wait_take(t0);
            chk("vector", vec(i), last_vec);
            apb(0, ofs(0), 0);
            chk("gie_cleared", 0, rd[0]);
            apb(0, ofs(RG[i]), 0);
            chk("flag_cleared", 0, rd[FB[i]]);
            do_return_from_interrupt();
        end
        // fill the stack, then one more request waits for a pop
        apb(1, ofs(1), 8'h7f);
        for (int i = 0; i < 2; i++)
        begin
            t0 = takes;
            set_gie();
            wait_take(t0);
        end
        t0 = takes;
        set_gie();
        repeat (20) @(posedge pclk);
        chk("held_when_full", t0, takes);
        apb(0, vic_pkg::OFS_STATUS, 0);
        chk("status", 32'he4, rd);
        do_return_from_interrupt();
        wait_take(t0);
        chk("vector_after_pop", vec(5), last_vec);
        do_return_from_interrupt();
        do_return_from_interrupt();
        summarize();
    end
endmodule
`default_nettype wire
